/* File: hw/ifd_pkg.sv */
// Package with the field layouts, encodings and carriers of the field decoder.
package ifd_pkg;

  // Field positions inside the addressing byte and the scale-index-base byte.
  localparam int MOD_LSB = 6;
  localparam int REG_LSB = 3;
  localparam int RM_LSB = 0;
  localparam int SCALE_LSB = 6;
  localparam int INDEX_LSB = 3;
  localparam int BASE_LSB = 0;

  // Field positions inside the primary opcode byte, except SEG_LONG_LSB, which is a position in the addressing byte.
  localparam int W_BIT = 0;
  localparam int D_BIT = 1;
  localparam int S_BIT = 1;
  localparam int OPC_REG_LSB = 0;
  localparam int COND_LSB = 0;
  localparam int SEG_SHORT_LSB = 3;
  localparam int SEG_LONG_LSB = 3;

  // Operand widths in bits.
  localparam logic [5:0] WIDTH_BYTE = 6'h08;
  localparam logic [5:0] WIDTH_WORD = 6'h10;
  localparam logic [5:0] WIDTH_DWORD = 6'h20;

  // Value of the mod part that makes the operand a register.
  localparam logic [1:0] MOD_REGISTER = 2'h3;

  // Reset value of every decoded output word.
  localparam logic [7:0] RESET_BYTE = 8'h00;

  // Where the register-select field is taken from.
  typedef enum logic [1:0] {
    ifd_regsrc_opcode = 2'b00,
    ifd_regsrc_middle = 2'b01,
    ifd_regsrc_low = 2'b10
  } ifd_regsrc_t;

  // Size of a general register part that is selected.
  typedef enum logic [1:0] {
    ifd_part_low_byte = 2'b00,
    ifd_part_high_byte = 2'b01,
    ifd_part_word = 2'b10,
    ifd_part_dword = 2'b11
  } ifd_part_t;

  // Segment registers.
  typedef enum logic [2:0] {
    ifd_seg_extra = 3'b000,
    ifd_seg_code = 3'b001,
    ifd_seg_stack = 3'b010,
    ifd_seg_data = 3'b011,
    ifd_seg_fourth_extra = 3'b100,
    ifd_seg_fifth_extra = 3'b101
  } ifd_seg_t;

  // Instruction bytes and context from the fetch and prefix stage.
  typedef struct packed {
    logic valid;
    logic [7:0] opcode;
    logic [7:0] modrm;
    logic [7:0] sib;
    ifd_regsrc_t reg_source;
    logic has_width_bit;
    logic has_seg_short;
    logic has_seg_long;
    logic protected_mode;
    logic virtual_8086;
    logic code_default_big;
    logic operand_prefix;
    logic address_prefix;
  } ifd_in_t;

  // A selected general register.
  typedef struct packed {
    logic [2:0] index;
    ifd_part_t part;
  } ifd_greg_t;

  // Decoded fields for the execution datapath.
  typedef struct packed {
    logic valid;
    ifd_greg_t reg_op;
    ifd_greg_t rm_op;
    logic rm_is_register;
    logic [1:0] mod_part;
    logic [5:0] operand_width;
    logic operand_32;
    logic address_32;
    logic direction;
    logic sign_extend;
    logic [1:0] scale;
    logic [2:0] index_reg;
    logic [2:0] base_reg;
    logic [2:0] cond_select;
    logic cond_negate;
    ifd_seg_t segment;
    logic segment_valid;
    logic invalid;
  } ifd_out_t;

endpackage

/* File: hw/ifd_greg_sel.sv */
// Translation of a 3-bit register-select value into a general register part.
`timescale 1ns/1ns
module ifd_greg_sel
  import ifd_pkg::*;
(
  // Field and context.
  input wire logic [2:0] sel,
  input wire logic has_width_bit,
  input wire logic width_bit,
  input wire logic operand_32,
  // Selected register.
  output ifd_greg_t greg
);

  always_comb
  begin
    greg.index = sel;
    greg.part = operand_32 ? ifd_part_dword : ifd_part_word;
    if (has_width_bit && !width_bit)
    begin
      greg.index = {1'b0, sel[1:0]};
      greg.part = sel[2] ? ifd_part_high_byte : ifd_part_low_byte;
    end
    else if (has_width_bit)
    begin
      greg.part = operand_32 ? ifd_part_dword : ifd_part_word;
    end
  end

endmodule

/* File: hw/ifd_seg_sel.sv */
// Translation of the short and long segment-select fields.
`timescale 1ns/1ns
module ifd_seg_sel
  import ifd_pkg::*;
(
  // Fields.
  input wire logic [1:0] seg_short,
  input wire logic [2:0] seg_long,
  input wire logic use_long,
  // Result.
  output ifd_seg_t segment,
  output logic reserved
);

  always_comb
  begin
    segment = ifd_seg_t'({1'b0, seg_short});
    reserved = 1'b0;
    if (use_long)
    begin
      unique case (seg_long)
        3'b000: segment = ifd_seg_extra;
        3'b001: segment = ifd_seg_code;
        3'b010: segment = ifd_seg_stack;
        3'b011: segment = ifd_seg_data;
        3'b100: segment = ifd_seg_fourth_extra;
        3'b101: segment = ifd_seg_fifth_extra;
        default:
        begin
          segment = ifd_seg_extra;
          reserved = 1'b1;
        end
      endcase
    end
  end

endmodule

/* File: hw/ifd_decoder.sv */
// Instruction field decoder with registered outputs.
`timescale 1ns/1ns
module ifd_decoder
  import ifd_pkg::*;
(
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst,
  // Instruction bytes from the fetch and prefix stage.
  input wire ifd_in_t fetch,
  // Decoded fields to the execution datapath.
  output ifd_out_t decoded
);

  logic default_big;
  logic next_operand_32;
  logic next_address_32;
  logic width_bit;
  logic [2:0] reg_sel;
  ifd_greg_t reg_greg;
  ifd_greg_t rm_greg;
  ifd_seg_t seg;
  logic seg_reserved;
  ifd_out_t next_decoded;
  logic out_valid;
  ifd_greg_t out_reg_op;
  ifd_greg_t out_rm_op;
  logic out_rm_is_register;
  logic [1:0] out_mod_part;
  logic [5:0] out_operand_width;
  logic out_operand_32;
  logic out_address_32;
  logic out_direction;
  logic out_sign_extend;
  logic [1:0] out_scale;
  logic [2:0] out_index_reg;
  logic [2:0] out_base_reg;
  logic [2:0] out_cond_select;
  logic out_cond_negate;
  ifd_seg_t out_segment;
  logic out_segment_valid;
  logic out_invalid;

  always_comb
  begin
    default_big = fetch.protected_mode && !fetch.virtual_8086
      && fetch.code_default_big;
    next_operand_32 = default_big ^ fetch.operand_prefix;
    next_address_32 = default_big ^ fetch.address_prefix;
    width_bit = fetch.opcode[W_BIT];
  end

  always_comb
  begin
    unique case (fetch.reg_source)
      ifd_regsrc_middle: reg_sel = fetch.modrm[REG_LSB +: 3];
      ifd_regsrc_low: reg_sel = fetch.modrm[RM_LSB +: 3];
      ifd_regsrc_opcode: reg_sel = fetch.opcode[OPC_REG_LSB +: 3];
      default: reg_sel = fetch.opcode[OPC_REG_LSB +: 3];
    endcase
  end

  ifd_greg_sel u_reg_sel (
    .sel(reg_sel),
    .has_width_bit(fetch.has_width_bit),
    .width_bit(width_bit),
    .operand_32(next_operand_32),
    .greg(reg_greg)
  );

  ifd_greg_sel u_rm_sel (
    .sel(fetch.modrm[RM_LSB +: 3]),
    .has_width_bit(fetch.has_width_bit),
    .width_bit(width_bit),
    .operand_32(next_operand_32),
    .greg(rm_greg)
  );

  ifd_seg_sel u_seg_sel (
    .seg_short(fetch.opcode[SEG_SHORT_LSB +: 2]),
    .seg_long(fetch.modrm[SEG_LONG_LSB +: 3]),
    .use_long(fetch.has_seg_long),
    .segment(seg),
    .reserved(seg_reserved)
  );

  always_comb
  begin
    next_decoded = '0;
    next_decoded.valid = fetch.valid;
    next_decoded.reg_op = reg_greg;
    next_decoded.rm_op = rm_greg;
    next_decoded.mod_part = fetch.modrm[MOD_LSB +: 2];
    next_decoded.rm_is_register =
      (fetch.modrm[MOD_LSB +: 2] == MOD_REGISTER);
    next_decoded.operand_32 = next_operand_32;
    next_decoded.address_32 = next_address_32;
    if (fetch.has_width_bit && !width_bit)
    begin
      next_decoded.operand_width = WIDTH_BYTE;
    end
    else
    begin
      next_decoded.operand_width = next_operand_32 ? WIDTH_DWORD
        : WIDTH_WORD;
    end
    next_decoded.direction = fetch.opcode[D_BIT];
    next_decoded.sign_extend = fetch.opcode[S_BIT];
    next_decoded.scale = fetch.sib[SCALE_LSB +: 2];
    next_decoded.index_reg = fetch.sib[INDEX_LSB +: 3];
    next_decoded.base_reg = fetch.sib[BASE_LSB +: 3];
    next_decoded.cond_select = fetch.opcode[COND_LSB + 1 +: 3];
    next_decoded.cond_negate = fetch.opcode[COND_LSB];
    next_decoded.segment_valid = (fetch.has_seg_short
      || fetch.has_seg_long) && !seg_reserved;
    next_decoded.segment = seg;
    next_decoded.invalid = fetch.has_seg_long && seg_reserved;
  end

  // One output register for each concern.
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      out_valid <= 1'b0;
    end
    else
    begin
      out_valid <= next_decoded.valid;
    end
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      out_reg_op <= '0;
    end
    else
    begin
      out_reg_op <= next_decoded.reg_op;
    end
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      out_rm_op <= '0;
    end
    else
    begin
      out_rm_op <= next_decoded.rm_op;
    end
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      out_mod_part <= 2'h0;
      out_rm_is_register <= 1'b0;
    end
    else
    begin
      out_mod_part <= next_decoded.mod_part;
      out_rm_is_register <= next_decoded.rm_is_register;
    end
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      out_operand_width <= 6'h00;
    end
    else
    begin
      out_operand_width <= next_decoded.operand_width;
    end
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      out_operand_32 <= 1'b0;
      out_address_32 <= 1'b0;
    end
    else
    begin
      out_operand_32 <= next_decoded.operand_32;
      out_address_32 <= next_decoded.address_32;
    end
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      out_direction <= 1'b0;
      out_sign_extend <= 1'b0;
    end
    else
    begin
      out_direction <= next_decoded.direction;
      out_sign_extend <= next_decoded.sign_extend;
    end
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      out_scale <= 2'h0;
      out_index_reg <= 3'h0;
      out_base_reg <= 3'h0;
    end
    else
    begin
      out_scale <= next_decoded.scale;
      out_index_reg <= next_decoded.index_reg;
      out_base_reg <= next_decoded.base_reg;
    end
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      out_cond_select <= 3'h0;
      out_cond_negate <= 1'b0;
    end
    else
    begin
      out_cond_select <= next_decoded.cond_select;
      out_cond_negate <= next_decoded.cond_negate;
    end
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      out_segment <= ifd_seg_extra;
    end
    else
    begin
      out_segment <= next_decoded.segment;
    end
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      out_segment_valid <= 1'b0;
      out_invalid <= 1'b0;
    end
    else
    begin
      out_segment_valid <= next_decoded.segment_valid;
      out_invalid <= next_decoded.invalid;
    end
  end

  // The output word is wired straight from the registers above.
  always_comb
  begin
    decoded.valid = out_valid;
    decoded.reg_op = out_reg_op;
    decoded.rm_op = out_rm_op;
    decoded.rm_is_register = out_rm_is_register;
    decoded.mod_part = out_mod_part;
    decoded.operand_width = out_operand_width;
    decoded.operand_32 = out_operand_32;
    decoded.address_32 = out_address_32;
    decoded.direction = out_direction;
    decoded.sign_extend = out_sign_extend;
    decoded.scale = out_scale;
    decoded.index_reg = out_index_reg;
    decoded.base_reg = out_base_reg;
    decoded.cond_select = out_cond_select;
    decoded.cond_negate = out_cond_negate;
    decoded.segment = out_segment;
    decoded.segment_valid = out_segment_valid;
    decoded.invalid = out_invalid;
  end

endmodule

/* File: tb/ifd_fetch_model.sv */
// Fetch stage model.
`timescale 1ns/1ns
module ifd_fetch_model
  import ifd_pkg::*;
(
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst,
  // Request and bytes out.
  input wire ifd_in_t req,
  output ifd_in_t fetch
);
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      fetch <= '0;
    else
      fetch <= req;
  end
endmodule

/* File: tb/ifd_checker.sv */
// Decoder checker.
`timescale 1ns/1ns
module ifd_checker
  import ifd_pkg::*;
(
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst,
  // Ports.
  input wire ifd_in_t fetch,
  input wire ifd_out_t decoded
);
  logic armed;
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      armed <= 1'b0;
    else
      armed <= 1'b1;
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  AST_DIR: assert property (armed |->
    decoded.direction == $past(fetch.opcode[1])) else $error("dir");
  AST_SGN: assert property (armed |->
    decoded.sign_extend == $past(fetch.opcode[1])) else $error("sign");
  AST_MOD: assert property (armed |-> decoded.rm_is_register ==
    ($past(fetch.modrm[7:6]) == 2'h3)) else $error("mod");
  AST_SIB: assert property (armed |-> {decoded.scale,
    decoded.index_reg, decoded.base_reg} == $past(fetch.sib))
    else $error("sib");
  AST_CND: assert property (armed |-> {decoded.cond_select,
    decoded.cond_negate} == $past(fetch.opcode[3:0])) else $error("cond");
  AST_WID: assert property (armed |-> decoded.operand_width ==
    ($past(fetch.has_width_bit && !fetch.opcode[0]) ? WIDTH_BYTE :
    decoded.operand_32 ? WIDTH_DWORD : WIDTH_WORD)) else $error("width");
  AST_RES: assert property (armed && $past(fetch.has_seg_long &&
    fetch.modrm[5:4] == 2'h3) |-> decoded.invalid && !decoded.segment_valid)
    else $error("reserved");
  AST_SHO: assert property (armed && $past(fetch.has_seg_short &&
    !fetch.has_seg_long) |-> !decoded.segment[2]) else $error("short");
  AST_SIZ: assert property (armed |-> decoded.operand_32 ==
    ($past(fetch.protected_mode && !fetch.virtual_8086 &&
    fetch.code_default_big) ^ $past(fetch.operand_prefix)))
    else $error("size");
  cover property (decoded.invalid);
  cover property (decoded.operand_32);
  cover property (decoded.reg_op.part == ifd_part_high_byte);
endmodule
bind ifd_decoder ifd_checker ifd_checker_inst (.core_clk(core_clk),
  .rst(rst), .fetch(fetch), .decoded(decoded));

/* File: tb/ifd_decoder_test.sv */
// Decoder testbench.
`timescale 1ns/1ns
module ifd_decoder_test import ifd_pkg::*;;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  ifd_in_t req = '0;
  ifd_in_t fetch;
  ifd_out_t decoded;
  int mismatches = 0;
  int check_count = 0;
  always #25 core_clk = ~core_clk;
  ifd_fetch_model ifd_fetch_model_inst (.core_clk(core_clk), .rst(rst),
    .req(req), .fetch(fetch));
  ifd_decoder ifd_decoder_inst (.core_clk(core_clk), .rst(rst),
    .fetch(fetch), .decoded(decoded));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic go(input ifd_in_t x);
    @(posedge core_clk);
    req <= x;
    repeat (2) @(posedge core_clk);
    #1;
  endtask
  task automatic results();
    $display("checks %0d bad %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial
  begin
    #100000;
    mismatches++;
    results();
  end
  initial
  begin
    ifd_in_t x;
    logic b;
    logic [2:0] e;
    logic [2:0] f;
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    for (int m = 0; m < 32; m++)
    begin
      x = '0;
      x.has_width_bit = 1'b1;
      {x.opcode[0], x.protected_mode, x.virtual_8086} = m[4:2];
      {x.code_default_big, x.operand_prefix} = m[1:0];
      x.address_prefix = ~m[0];
      b = m[3] & ~m[2] & m[1];
      go(x);
      chk({2'h0, decoded.operand_width}, {2'h0, !m[4] ? WIDTH_BYTE :
        b ^ m[0] ? WIDTH_DWORD : WIDTH_WORD});
      chk({7'h0, decoded.address_32}, {7'h0, b ^ ~m[0]});
    end
    $display("size test done");
    for (int s = 0; s < 8; s++)
      for (int k = 0; k < 4; k++)
      begin
        x = '0;
        x.valid = 1'b1;
        x.protected_mode = 1'b1;
        x.code_default_big = s[0];
        x.reg_source = k == 3 ? ifd_regsrc_low : k == 2 ?
          ifd_regsrc_opcode : ifd_regsrc_middle;
        x.modrm = {2'h3, s[2:0], ~s[2:0]};
        x.has_width_bit = k != 2;
        x.opcode = k == 2 ? {5'h00, s[2:0]} : {7'h00, k[0]};
        e = k == 3 ? ~s[2:0] : s[2:0];
        f = ~s[2:0];
        go(x);
        chk({3'h0, decoded.reg_op}, {3'h0, k == 0 ?
          {1'b0, e[1:0], e[2] ? ifd_part_high_byte : ifd_part_low_byte} :
          {e, s[0] ? ifd_part_dword : ifd_part_word}});
        chk({2'h0, decoded.valid, decoded.rm_op},
          {2'h0, 1'b1, k == 0 ?
          {1'b0, f[1:0], f[2] ? ifd_part_high_byte : ifd_part_low_byte} :
          {f, s[0] ? ifd_part_dword : ifd_part_word}});
      end
    $display("register test done");
    for (int s = 0; s < 12; s++)
    begin
      x = '0;
      x.has_seg_long = s < 8;
      x.has_seg_short = 1'b1;
      x.opcode = {3'h0, ~s[1:0], 3'h0};
      x.modrm = {2'h0, s[2:0], 3'h0};
      if (s > 7)
        x.opcode = {3'h0, s[1:0], 3'h0};
      b = s == 6 || s == 7;
      go(x);
      chk({7'h0, decoded.invalid}, {7'h0, b});
      chk({4'h0, decoded.segment_valid, decoded.segment},
        {4'h0, !b, b ? 3'h0 : s > 7 ? {1'b0, s[1:0]} : s[2:0]});
    end
    $display("segment test done");
    for (int i = 0; i < 8; i++)
    begin
      x = '0;
      x.opcode = 8'h0b << i;
      x.modrm = x.opcode;
      x.sib = x.opcode ^ 8'h97;
      go(x);
      chk({6'h0, decoded.direction, decoded.sign_extend},
        {6'h0, x.opcode[1], x.opcode[1]});
      chk({4'h0, decoded.cond_select, decoded.cond_negate},
        {4'h0, x.opcode[3:0]});
      chk({decoded.scale, decoded.index_reg, decoded.base_reg}, x.sib);
      chk({4'h0, decoded.valid, decoded.mod_part,
        decoded.rm_is_register}, {4'h0, x.valid, x.modrm[7:6],
        x.modrm[7:6] == 2'h3});
    end
    $display("field test done");
    @(posedge core_clk);
    rst <= 1'b1;
    #1;
    chk({7'h0, decoded != '0}, 8'h00);
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    go(x);
    chk({decoded.scale, decoded.index_reg, decoded.base_reg}, x.sib);
    $display("reset test done");
    results();
  end
endmodule
